// file: rtl/bbe_engine.sv
// How it works
// - host expansion with transparency skips zero bits
// - blend primary and secondary pixels to destination
// - picture mode uses opacity register as alpha
// - 16-bit pixel mode: top nibble alpha, twelve-bit colour
// - 8-bit pixel mode: top two alpha, palette index
// - two-bit alpha maps 0, 10/32, 21/32, full
// - four-bit alpha maps 2n/32, fifteen is full
// - host blending takes primary pixels from host writes
// - memory expansion word width from depth field
// - split words MSB first, left to right
// - ones foreground, zeros background, extras discarded
// - memory expansion with transparency skips zero bits
// - solid fill writes foreground into whole window
// - foreground and background from three byte registers
// - sources and destination walk the window rectangle
// - status busy bit set while operating
`timescale 1ns/1ps
`default_nettype none
`include "bbe_params.svh"

// small first-in first-out buffer on the primary pixel path
module bbe_fifo #(
	parameter int W = 24,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         flush,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_q [D];        // storage words
	logic [AW-1:0] wr_q;            // write pointer
	logic [AW-1:0] rd_q;            // read pointer
	logic [AW:0]   cnt_q;           // words held
	logic          push;
	logic          pop;

	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("bbe_fifo depth must be a power of two, at least 2");
	end

	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage written only on push
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count; flush drops leftovers of a previous run
	always_ff @(posedge core_clk) begin
		if (reset || flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // bbe_fifo

module bbe_engine import bbe_pkg::*; #(
	parameter int ADDR_W     = 12,
	parameter int FIFO_DEPTH = 4,
	parameter int HOST_BITS  = 16
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset,
	// axi4-lite write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	// axi4-lite write data
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// axi4-lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// axi4-lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// primary source words read from display memory
	input  wire logic              pri_valid,
	output logic                   pri_ready,
	input  wire logic [23:0]       pri_data,
	// secondary source pixels read from display memory
	input  wire logic              sec_valid,
	output logic                   sec_ready,
	input  wire logic [23:0]       sec_data,
	// destination pixel stream, rgb888
	output logic                   dst_valid,
	input  wire logic              dst_ready,
	output logic [23:0]            dst_data,
	output logic                   dst_write,
	output logic [15:0]            dst_x,
	output logic [15:0]            dst_y
);
	if (ADDR_W < 11 || (HOST_BITS != 8 && HOST_BITS != 16)) begin : g_chk
		$error("bbe_engine: ADDR_W must exceed 10, HOST_BITS 8 or 16");
	end

	// register file
	logic [7:0]  ctrl1_q, ctrl2_q, opac_q;     // control and opacity
	logic [7:0]  fg_q [3];                     // foreground r,g,b
	logic [7:0]  bg_q [3];                     // background r,g,b
	logic [15:0] width_q, height_q;            // window size
	logic [11:0] pal_q [64];                   // palette memory, rgb444
	bbe_state_t  state_q;                      // engine state
	logic        busy_q;                       // mirrored into status
	logic [3:0]  op_q;                         // operation latched at start
	logic [15:0] x_q, y_q;                     // window walk
	logic [3:0]  bit_q;                        // current expansion bit
	logic        last_bit_q;                   // bit used by the last pixel
	// bus slave holding
	logic              aw_full_q, w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	// input holding stages
	logic        pri_full_q, sec_full_q;
	logic [23:0] pri_buf_q, sec_buf_q;

	// ---- operation classes ----
	logic is_exp, is_transp, is_blend, is_host, is_fill;
	assign is_exp    = op_q <= `BBE_OP_MEM_EXPT;
	assign is_transp = op_q == `BBE_OP_HOST_EXPT || op_q == `BBE_OP_MEM_EXPT;
	assign is_blend  = op_q == `BBE_OP_MEM_BLEND || op_q == `BBE_OP_HOST_BLEND;
	assign is_host   = op_q == `BBE_OP_HOST_EXP || op_q == `BBE_OP_HOST_EXPT
	                || op_q == `BBE_OP_HOST_BLEND;
	assign is_fill   = op_q == `BBE_OP_FILL;

	logic [1:0] depth;
	assign depth = ctrl2_q[`BBE_C2_DEPTH_HI:`BBE_C2_DEPTH_LO];

	// ---- bus write path ----
	logic [7:0] w_idx, r_idx;
	logic       w_hi_ok, r_hi_ok, w_is_host, w_commit, fifo_in_ready;
	assign w_idx     = aw_addr_q[9:2];
	assign r_idx     = s_axi_araddr[9:2];
	assign w_hi_ok   = aw_addr_q[ADDR_W-1:10] == '0;
	assign r_hi_ok   = s_axi_araddr[ADDR_W-1:10] == '0;
	assign w_is_host = w_hi_ok && w_idx == `BBE_IDX_HOSTDATA;
	// host data waits while the buffer is full: back-pressure via bvalid
	assign w_commit  = aw_full_q && w_full_q && !s_axi_bvalid
	                && (!w_is_host || !(busy_q && is_host) || fifo_in_ready);

	function automatic logic mapped(input logic [7:0] i);
		case (i)
			`BBE_IDX_CTRL1, `BBE_IDX_CTRL2, `BBE_IDX_OPACITY,
			`BBE_IDX_FG_RED, `BBE_IDX_FG_GREEN, `BBE_IDX_FG_BLUE,
			`BBE_IDX_BG_RED, `BBE_IDX_BG_GREEN, `BBE_IDX_BG_BLUE,
			`BBE_IDX_WIDTH, `BBE_IDX_HEIGHT, `BBE_IDX_START,
			`BBE_IDX_STATUS, `BBE_IDX_HOSTDATA, `BBE_IDX_PALETTE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// address and data are taken independently, in either order
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BBE_RESP_OKAY;
			aw_addr_q     <= '0;
			w_data_q      <= '0;
			w_strb_q      <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (w_commit) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (w_commit) begin
				w_full_q <= 1'b0;
			end
			// ready only while the slot is empty and stays empty
			s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready)
			              || w_commit;
			s_axi_wready  <= !w_full_q && !(s_axi_wvalid && s_axi_wready) || w_commit;
			if (w_commit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (w_hi_ok && mapped(w_idx)) ? `BBE_RESP_OKAY
				                                          : `BBE_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register stores; byte lane 0 for bytes, lanes 0-1 for sizes
	logic start_go;
	assign start_go = w_commit && w_hi_ok && w_idx == `BBE_IDX_START && w_strb_q[0]
	               && w_data_q[0] && state_q == BBE_IDLE
	               && width_q != '0 && height_q != '0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl1_q  <= `BBE_RST_BYTE;
			ctrl2_q  <= `BBE_RST_BYTE;
			opac_q   <= `BBE_RST_BYTE;
			fg_q     <= '{default: `BBE_RST_BYTE};
			bg_q     <= '{default: `BBE_RST_BYTE};
			width_q  <= `BBE_RST_SIZE;
			height_q <= `BBE_RST_SIZE;
		end else if (w_commit && w_hi_ok && w_strb_q[0]) begin
			case (w_idx)
				`BBE_IDX_CTRL1:    ctrl1_q  <= w_data_q[7:0];
				`BBE_IDX_CTRL2:    ctrl2_q  <= w_data_q[7:0];
				`BBE_IDX_OPACITY:  opac_q   <= w_data_q[7:0];
				`BBE_IDX_FG_RED:   fg_q[0]  <= w_data_q[7:0];
				`BBE_IDX_FG_GREEN: fg_q[1]  <= w_data_q[7:0];
				`BBE_IDX_FG_BLUE:  fg_q[2]  <= w_data_q[7:0];
				`BBE_IDX_BG_RED:   bg_q[0]  <= w_data_q[7:0];
				`BBE_IDX_BG_GREEN: bg_q[1]  <= w_data_q[7:0];
				`BBE_IDX_BG_BLUE:  bg_q[2]  <= w_data_q[7:0];
				`BBE_IDX_WIDTH:    width_q  <= w_data_q[15:0];
				`BBE_IDX_HEIGHT:   height_q <= w_data_q[15:0];
				default: ;
			endcase
		end
	end

	// palette fill, index and rgb444 in one word
	always_ff @(posedge core_clk) begin
		if (w_commit && w_hi_ok && w_idx == `BBE_IDX_PALETTE && w_strb_q[0]) begin
			pal_q[w_data_q[`BBE_PAL_IDX_HI:`BBE_PAL_IDX_LO]] <= w_data_q[11:0];
		end
	end

	// ---- bus read path: one cycle after the address is taken ----
	logic [31:0] rd_val;
	always_comb begin
		rd_val = '0;
		case (r_idx)
			`BBE_IDX_CTRL1:    rd_val[7:0]  = ctrl1_q;
			`BBE_IDX_CTRL2:    rd_val[7:0]  = ctrl2_q;
			`BBE_IDX_OPACITY:  rd_val[7:0]  = opac_q;
			`BBE_IDX_FG_RED:   rd_val[7:0]  = fg_q[0];
			`BBE_IDX_FG_GREEN: rd_val[7:0]  = fg_q[1];
			`BBE_IDX_FG_BLUE:  rd_val[7:0]  = fg_q[2];
			`BBE_IDX_BG_RED:   rd_val[7:0]  = bg_q[0];
			`BBE_IDX_BG_GREEN: rd_val[7:0]  = bg_q[1];
			`BBE_IDX_BG_BLUE:  rd_val[7:0]  = bg_q[2];
			`BBE_IDX_WIDTH:    rd_val[15:0] = width_q;
			`BBE_IDX_HEIGHT:   rd_val[15:0] = height_q;
			`BBE_IDX_STATUS:   rd_val[`BBE_ST_BUSY] = busy_q;
			default: ;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `BBE_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= (r_hi_ok && mapped(r_idx)) ? rd_val : '0;
				s_axi_rresp  <= (r_hi_ok && mapped(r_idx)) ? `BBE_RESP_OKAY
				                                          : `BBE_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---- source buffering ----
	logic        fifo_in_valid, fifo_out_valid, fifo_pop;
	logic [23:0] fifo_in_data, fifo_out_data;
	assign fifo_in_valid = is_host ? (w_commit && w_is_host && busy_q) : pri_full_q;
	assign fifo_in_data  = is_host ? w_data_q[23:0] : pri_buf_q;

	bbe_fifo #(.W(24), .D(FIFO_DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.flush     (start_go),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ---- pixel step ----
	logic need_src, fire, row_end, last_pix, cur_bit, sec_pop, pri_take, sec_take;
	logic [3:0] word_top, start_eff;
	assign need_src = is_exp || is_blend;
	assign fire     = busy_q && (!dst_valid || dst_ready)
	               && (!need_src || fifo_out_valid) && (!is_blend || sec_full_q);
	assign row_end  = x_q == width_q - 16'h0001;
	assign last_pix = row_end && y_q == height_q - 16'h0001;
	// word width: host width for host writes, else depth field
	assign word_top = is_host ? 4'(HOST_BITS - 1)
	                : (depth == `BBE_DEPTH_16 ? 4'hF : 4'h7);
	assign start_eff = ctrl1_q[`BBE_C1_START_HI:`BBE_C1_START_LO] & word_top;
	assign cur_bit  = fifo_out_data[bit_q];
	// a word is used up at bit zero; the rest of a row's word is dropped
	assign fifo_pop = fire && (is_blend || (is_exp && (bit_q == '0 || row_end)));
	assign sec_pop  = fire && is_blend;
	assign pri_take = pri_valid && pri_ready;
	assign sec_take = sec_valid && sec_ready;

	// one-word holding stages keep the ready outputs registered
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pri_full_q <= 1'b0;
			sec_full_q <= 1'b0;
			pri_ready  <= 1'b0;
			sec_ready  <= 1'b0;
			pri_buf_q  <= '0;
			sec_buf_q  <= '0;
		end else begin
			if (pri_take) begin
				pri_full_q <= 1'b1;
				pri_buf_q  <= pri_data;
			end else if (start_go || (pri_full_q && fifo_in_ready && !is_host)) begin
				// start drops a word left over from the previous run
				pri_full_q <= 1'b0;
			end
			if (sec_take) begin
				sec_full_q <= 1'b1;
				sec_buf_q  <= sec_data;
			end else if (sec_pop || start_go) begin
				// a stale secondary pixel would shift the whole window
				sec_full_q <= 1'b0;
			end
			pri_ready <= busy_q && !is_host && need_src && !pri_full_q && !pri_take;
			sec_ready <= busy_q && is_blend && !sec_full_q && !sec_take;
		end
	end

	// ---- blending ----
	logic [23:0] p_rgb, s_rgb, blend_rgb;
	logic [5:0]  alpha;
	logic        pix_mode;
	assign pix_mode = ctrl2_q[`BBE_C2_PIXMODE] && depth != `BBE_DEPTH_24;

	function automatic logic [23:0] to_rgb(input logic [23:0] d, input logic [1:0] dp);
		case (dp)
			`BBE_DEPTH_8:  to_rgb = {d[7:5], 5'h00, d[4:2], 5'h00, d[1:0], 6'h00};
			`BBE_DEPTH_16: to_rgb = {d[15:11], 3'h0, d[10:5], 2'h0, d[4:0], 3'h0};
			default:       to_rgb = d;
		endcase
	endfunction

	function automatic logic [23:0] from444(input logic [11:0] c);
		from444 = {c[11:8], 4'h0, c[7:4], 4'h0, c[3:0], 4'h0};
	endfunction

	// channel blend in thirty-seconds, fraction truncated
	function automatic logic [7:0] mix(input logic [7:0] p, input logic [7:0] s,
	                                   input logic [5:0] a);
		logic [14:0] sum;
		sum = 15'(p * a) + 15'(s * (`BBE_ALPHA_FULL - a));
		mix = sum[7+`BBE_ALPHA_SHIFT:`BBE_ALPHA_SHIFT];
	endfunction

	always_comb begin
		p_rgb = to_rgb(fifo_out_data, depth);
		s_rgb = to_rgb(sec_buf_q, depth);
		alpha = (opac_q > 8'(`BBE_ALPHA_FULL)) ? `BBE_ALPHA_FULL : opac_q[5:0];
		if (pix_mode && depth == `BBE_DEPTH_16) begin
			s_rgb = from444(sec_buf_q[11:0]);
			alpha = (sec_buf_q[15:12] == 4'hF) ? `BBE_ALPHA_FULL
			      : {1'b0, sec_buf_q[15:12], 1'b0};
		end else if (pix_mode) begin
			s_rgb = from444(pal_q[sec_buf_q[5:0]]);
			case (sec_buf_q[7:6])
				2'h0:    alpha = 6'h00;
				2'h1:    alpha = `BBE_ALPHA8_ONE;
				2'h2:    alpha = `BBE_ALPHA8_TWO;
				default: alpha = `BBE_ALPHA_FULL;
			endcase
		end
		blend_rgb = {mix(p_rgb[23:16], s_rgb[23:16], alpha),
		             mix(p_rgb[15:8], s_rgb[15:8], alpha),
		             mix(p_rgb[7:0], s_rgb[7:0], alpha)};
	end

	// ---- sequencing ----
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= BBE_IDLE;
			busy_q  <= 1'b0;
			op_q    <= `BBE_OP_FILL;
			x_q     <= '0;
			y_q     <= '0;
			bit_q   <= '0;
		end else begin
			case (state_q)
				BBE_IDLE: begin
					if (start_go) begin
						state_q <= BBE_RUN;
						busy_q  <= 1'b1;
						op_q    <= ctrl1_q[`BBE_C1_OP_HI:`BBE_C1_OP_LO];
						x_q     <= '0;
						y_q     <= '0;
						bit_q   <= start_eff;
					end
				end
				BBE_RUN: begin
					if (fire) begin
						bit_q <= (bit_q == '0 || row_end) ? start_eff : bit_q - 4'h1;
						if (last_pix) begin
							state_q <= BBE_IDLE;
							busy_q  <= 1'b0;
						end else if (row_end) begin
							x_q <= '0;
							y_q <= y_q + 16'h0001;
						end else begin
							x_q <= x_q + 16'h0001;
						end
					end
				end
				default: begin
					state_q <= BBE_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	// destination pixel register, held until taken
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dst_valid  <= 1'b0;
			dst_data   <= '0;
			dst_write  <= 1'b0;
			dst_x      <= '0;
			dst_y      <= '0;
			last_bit_q <= 1'b0;
		end else if (fire) begin
			dst_valid  <= 1'b1;
			dst_x      <= x_q;
			dst_y      <= y_q;
			last_bit_q <= cur_bit;
			dst_write  <= !(is_exp && is_transp && !cur_bit);
			if (is_fill) begin
				dst_data <= {fg_q[0], fg_q[1], fg_q[2]};
			end else if (is_blend) begin
				dst_data <= blend_rgb;
			end else begin
				dst_data <= cur_bit ? {fg_q[0], fg_q[1], fg_q[2]}
				                    : {bg_q[0], bg_q[1], bg_q[2]};
			end
		end else if (dst_ready) begin
			dst_valid <= 1'b0;
		end
	end

	// ---- checks ----
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_start_sets_busy: assert property (start_go |=> busy_q && state_q == BBE_RUN)
		else $error("busy not raised after start");
	a_done_clears_busy: assert property (fire && last_pix |=> !busy_q)
		else $error("busy still set after last pixel");
	a_fill_foreground: assert property (fire && is_fill |=>
		dst_valid && dst_write && dst_data == {fg_q[0], fg_q[1], fg_q[2]})
		else $error("fill pixel not foreground");
	a_expand_colour: assert property (fire && is_exp && !is_transp |=>
		dst_write && dst_data == (last_bit_q ? {fg_q[0], fg_q[1], fg_q[2]}
		                                     : {bg_q[0], bg_q[1], bg_q[2]}))
		else $error("expanded pixel colour wrong");
	a_transp_skip: assert property (fire && is_exp && is_transp |=>
		dst_write == last_bit_q)
		else $error("transparent zero bit was written");
	a_alpha8_map: assert property (busy_q && is_blend && pix_mode
		&& depth == `BBE_DEPTH_8 && sec_buf_q[7:6] == 2'h2 |-> alpha == 6'h15)
		else $error("two-bit alpha map wrong");
	a_alpha16_map: assert property (busy_q && is_blend && pix_mode
		&& depth == `BBE_DEPTH_16 |-> alpha == ((sec_buf_q[15:12] == 4'hF) ? 6'h20
		                              : 6'(sec_buf_q[15:12] * 2)))
		else $error("four-bit alpha map wrong");
	a_blend_result: assert property (fire && is_blend |=>
		dst_data == $past(blend_rgb) && dst_write)
		else $error("blend result not delivered");
	a_dst_hold: assert property (dst_valid && !dst_ready |=>
		dst_valid && $stable(dst_data) && $stable(dst_x))
		else $error("destination pixel changed before taken");
	a_word_pop: assert property (fire && is_exp && bit_q == 4'h0 |-> fifo_pop)
		else $error("expansion word not consumed at bit zero");

	c_fill_done: cover property (fire && is_fill && last_pix);
	c_blend_pal: cover property (fire && is_blend && pix_mode && depth == `BBE_DEPTH_8);
	c_transp_skip: cover property (fire && is_transp && !cur_bit);
	c_fifo_full: cover property (busy_q && !fifo_in_ready);
endmodule // bbe_engine
`default_nettype wire

// file: rtl/bbe_params.svh
`ifndef BBE_PARAMS_SVH
`define BBE_PARAMS_SVH

// register indices; byte address is four times the index
`define BBE_IDX_CTRL1      8'h91
`define BBE_IDX_CTRL2      8'h92
`define BBE_IDX_OPACITY    8'hB5
`define BBE_IDX_FG_RED     8'hD2
`define BBE_IDX_FG_GREEN   8'hD3
`define BBE_IDX_FG_BLUE    8'hD4
`define BBE_IDX_BG_RED     8'hD5
`define BBE_IDX_BG_GREEN   8'hD6
`define BBE_IDX_BG_BLUE    8'hD7
`define BBE_IDX_WIDTH      8'h40
`define BBE_IDX_HEIGHT     8'h41
`define BBE_IDX_START      8'h42
`define BBE_IDX_STATUS     8'h43
`define BBE_IDX_HOSTDATA   8'h44
`define BBE_IDX_PALETTE    8'h45

// field positions
`define BBE_C1_START_HI    7
`define BBE_C1_START_LO    4
`define BBE_C1_OP_HI       3
`define BBE_C1_OP_LO       0
`define BBE_C2_DEPTH_HI    6
`define BBE_C2_DEPTH_LO    5
`define BBE_C2_PIXMODE     0
`define BBE_ST_BUSY        3
`define BBE_PAL_IDX_HI     17
`define BBE_PAL_IDX_LO     12

// operation codes in the low nibble of control one
`define BBE_OP_HOST_EXP    4'h0
`define BBE_OP_HOST_EXPT   4'h1
`define BBE_OP_MEM_EXP     4'h2
`define BBE_OP_MEM_EXPT    4'h3
`define BBE_OP_MEM_BLEND   4'h4
`define BBE_OP_HOST_BLEND  4'h5
`define BBE_OP_FILL        4'h6

// source depth codes
`define BBE_DEPTH_8        2'h0
`define BBE_DEPTH_16       2'h1
`define BBE_DEPTH_24       2'h2

// alpha scale: weights are in thirty-seconds
`define BBE_ALPHA_FULL     6'h20
`define BBE_ALPHA8_ONE     6'h0A
`define BBE_ALPHA8_TWO     6'h15
`define BBE_ALPHA_SHIFT    5

// reset values and bus answers
`define BBE_RST_BYTE       8'h00
`define BBE_RST_SIZE       16'h0000
`define BBE_RESP_OKAY      2'h0
`define BBE_RESP_SLVERR    2'h2

`endif

// file: rtl/bbe_pkg.sv
package bbe_pkg;
	// engine sequencing states
	typedef enum logic {
		BBE_IDLE,
		BBE_RUN
	} bbe_state_t;
endpackage

// file: verification/bbe_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// display memory side: sources always offered, destination stalls at random
module bbe_mem_model (
	// clock and stall control
	input  wire logic        core_clk,
	input  wire logic        stall,
	// source words, changed by the bench only while idle
	input  wire logic [23:0] pri_word,
	input  wire logic [23:0] sec_word,
	output logic             pri_valid,
	output logic [23:0]      pri_data,
	output logic             sec_valid,
	output logic [23:0]      sec_data,
	// destination acceptance
	output logic             dst_ready
);
	int seed = 66;
	// one word per take, held unchanged across every pixel of the window
	assign pri_valid = 1'b1;
	assign pri_data  = pri_word;
	assign sec_valid = 1'b1;
	assign sec_data  = sec_word;
	// random back-pressure exercises the output hold path
	always_ff @(posedge core_clk) dst_ready <= stall ? 1'b0 : 1'($random(seed));
endmodule // bbe_mem_model
`default_nettype wire

// file: verification/blit_blend_expand_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bbe_params.svh"
module blit_blend_expand_engine_tb_top;
	logic core_clk = 0, reset = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, stall = 1;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, r;
	logic [1:0]  rs;
	logic [23:0] fg, bg, pw = 0, sw = 0, pe = 0, se = 0;
	logic [5:0]  al = 0;
	logic [3:0]  op = 0;
	logic [24:0] e;
	int seed = 66, error_cnt = 0, n_tests = 0, n_px = 0;
	wire logic awr, wrd, bv, arr, rv, pv, pr, sv, sr, dv, dr, dw;
	wire logic [1:0]  br, rr;
	wire logic [31:0] rd;
	wire logic [23:0] pd, sd, dd;
	wire logic [15:0] dx, dy;
	initial forever #50 core_clk = ~core_clk;
	bbe_engine bbe_engine_inst (.core_clk, .reset, .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .pri_valid(pv), .pri_ready(pr),
		.pri_data(pd), .sec_valid(sv), .sec_ready(sr), .sec_data(sd), .dst_valid(dv),
		.dst_ready(dr), .dst_data(dd), .dst_write(dw), .dst_x(dx), .dst_y(dy));
	bbe_mem_model bbe_mem_model_inst (.core_clk, .stall, .pri_word(pw), .sec_word(sw),
		.pri_valid(pv), .pri_data(pd), .sec_valid(sv), .sec_data(sd), .dst_ready(dr));
	task stop_test;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// write: address and data offered together, bready held until bvalid
	task wr(input logic [7:0] i, input logic [31:0] d);
		int t;
		@(posedge core_clk);
		awa <= {2'b00, i, 2'b00}; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		for (t = 0; t < 100; t++) begin
			@(posedge core_clk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if (bv) begin bre <= 0; rs = br; break; end
		end
		if (t == 100) begin error_cnt++; stop_test; end
	endtask
	task rdr(input logic [7:0] i);
		int t;
		@(posedge core_clk);
		ara <= {2'b00, i, 2'b00}; arv <= 1; rre <= 1;
		for (t = 0; t < 100; t++) begin
			@(posedge core_clk);
			if (arr) arv <= 0;
			if (rv) begin rre <= 0; r = rd; rs = rr; break; end
		end
		if (t == 100) begin error_cnt++; stop_test; end
	endtask
	// blend of one channel with weight al in thirty-seconds, fraction dropped
	function automatic logic [7:0] mx(input logic [7:0] p, input logic [7:0] s);
		logic [14:0] t;
		t = p * al + s * (6'd32 - al);
		return t[12:5];
	endfunction
	// expected write flag and colour of pixel x; start bit 7, msb first
	function automatic logic [24:0] ex(input logic [15:0] x);
		logic b;
		b = pw[3'd7 - x[2:0]];
		case (op)
			4'h6: ex = {1'b1, fg};
			4'h4: ex = {1'b1, mx(pe[23:16], se[23:16]), mx(pe[15:8], se[15:8]), mx(pe[7:0], se[7:0])};
			4'h1, 4'h3: ex = {b, fg};
			default: ex = {1'b1, b ? fg : bg};
		endcase
	endfunction
	// destination monitor: colour only compared where a write is made
	always @(posedge core_clk) if (dv === 1'b1 && dr === 1'b1) begin
		e = ex(dx);
		n_px++;
		chk({31'h0, dw}, {31'h0, e[24]});
		if (e[24]) chk({8'h00, dd}, {8'h00, e[23:0]});
	end
	task run(input logic [7:0] c1, input logic [15:0] w, input logic [15:0] h);
		int t;
		op = c1[3:0]; n_px = 0; stall <= 1;
		wr(`BBE_IDX_WIDTH, {16'h0000, w}); wr(`BBE_IDX_HEIGHT, {16'h0000, h});
		wr(`BBE_IDX_CTRL1, {24'h00_0000, c1}); wr(`BBE_IDX_START, 32'h0000_0001);
		// host expansion with transparency: one word per row written after the start
		if (c1[3:0] == `BBE_OP_HOST_EXPT) repeat (h) wr(`BBE_IDX_HOSTDATA, {8'h00, pw});
		rdr(`BBE_IDX_STATUS);
		chk(r & 32'h0000_0008, 32'h0000_0008);
		stall <= 0;
		for (t = 0; t < 60; t++) begin rdr(`BBE_IDX_STATUS); if (r[3] === 1'b0) break; end
		if (t == 60) begin error_cnt++; stop_test; end
		// busy drops when the last pixel is made, not when it is taken
		for (t = 0; t < 100 && dv !== 1'b0; t++) @(posedge core_clk);
		if (t == 100) error_cnt++;
		chk(n_px, w * h);
	endtask
	initial begin
		fg = 24'($random(seed)); bg = 24'($random(seed));
		pw = 24'($random(seed)); sw = 24'($random(seed));
		repeat (20) @(posedge core_clk);
		reset <= 0;
		rdr(`BBE_IDX_FG_RED);
		chk(r, 32'h0000_0000);
		rdr(8'h10);
		chk({30'h0, rs}, {30'h0, `BBE_RESP_SLVERR});
		wr(8'h10, 32'h0000_0005);
		chk({30'h0, rs}, {30'h0, `BBE_RESP_SLVERR});
		wr(`BBE_IDX_FG_RED, {24'h00_0000, fg[23:16]});
		wr(`BBE_IDX_FG_GREEN, {24'h00_0000, fg[15:8]});
		wr(`BBE_IDX_FG_BLUE, {24'h00_0000, fg[7:0]});
		wr(`BBE_IDX_BG_RED, {24'h00_0000, bg[23:16]});
		wr(`BBE_IDX_BG_GREEN, {24'h00_0000, bg[15:8]});
		wr(`BBE_IDX_BG_BLUE, {24'h00_0000, bg[7:0]});
		rdr(`BBE_IDX_FG_GREEN);
		chk(r, {24'h00_0000, fg[15:8]});
		wr(`BBE_IDX_CTRL2, 32'h0000_0000);
		run(8'h06, 16'd3, 16'd2);
		run(8'h72, 16'd8, 16'd1);
		run(8'h73, 16'd8, 16'd2);
		run(8'h71, 16'd8, 16'd2);
		wr(`BBE_IDX_CTRL2, 32'h0000_0040); wr(`BBE_IDX_OPACITY, 32'h0000_0010);
		al = 6'd16; pe = pw; se = sw;
		run(8'h04, 16'd4, 16'd1);
		// per-pixel mode at 16 bits: alpha in the top nibble, rgb444 below
		wr(`BBE_IDX_CTRL2, 32'h0000_0021);
		al = (sw[15:12] == 4'hF) ? 6'd32 : {1'b0, sw[15:12], 1'b0};
		pe = {pw[15:11], 3'h0, pw[10:5], 2'h0, pw[4:0], 3'h0};
		se = {sw[11:8], 4'h0, sw[7:4], 4'h0, sw[3:0], 4'h0};
		run(8'h04, 16'd4, 16'd1);
		stop_test;
	end
endmodule // blit_blend_expand_engine_tb_top
`default_nettype wire
